// >>> adc_serial_pkg.sv
/*
 package of constants for the serial converter control block.
 assumes REF_CLK at 100 MHz, far faster than either sampled link clock.
*/
package adc_serial_pkg;
   localparam int RESULT_BITS = 10;
   localparam int ADDR_BITS = 3;
   localparam int HEADER_BITS = 4;
   localparam int FRAME_BITS = 16;
   localparam int RIGHT_PAD = 6;
   localparam int CONV_CYCLES = 41;
   // sampling window in half serial clock periods (4.5 cycles)
   localparam int SAMPLE_HALVES = 9;
   localparam logic [15:0] SHIFT_RESET = 16'h0000;
   localparam logic [2:0] ADDR_RESET = 3'h0;
   localparam int VARIANT_ONE = 1;
   localparam int VARIANT_FOUR = 4;
   localparam int VARIANT_EIGHT = 8;
endpackage : adc_serial_pkg

// >>> edge_sync.sv
/*
 two flop synchroniser with edge detection on the second and third stage.
 assumes the input is asynchronous to clk.
*/
`timescale 1ns/1ps
module edge_sync
#(
   // idle level of the pin, so that reset leaves no false edge behind
   parameter logic INIT = 1'b0
)
(
   input wire logic clk,
   input wire logic rst,
   input wire logic din,
   output logic level,
   output logic rise,
   output logic fall
);
   logic [2:0] s_r;
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         s_r <= {3{INIT}};
      else
         s_r <= {s_r[1:0], din};
   end
   assign level = s_r[1];
   assign rise = s_r[1] & ~s_r[2];
   assign fall = ~s_r[1] & s_r[2];
endmodule : edge_sync

// >>> adc_serial_ctrl.sv
/*
 digital control and serial interface of a 10-bit converter with input mux.
 assumes serial_clk and conv_clk are slow pins sampled by REF_CLK; the
 analog core returns a result when asked (RESULT_IN valid at conversion end).
*/
// Summary of operation
// - first three bits form channel address
// - four-input variant ignores address msb
// - fourth bit selects justification
// - right justify emits six leading zeros
// - rising serial clock shifts address in
// - falling serial clock shifts result out
// - multi-input variants drive output only when both enables low
// - busy high exactly 41 conversion clocks
// - result loaded when busy falls
// - single-input variant gates with chip select
// - single-input variant always left justified
// - sample four and half serial cycles
// - msb address bit first, first edge
// - unfinished exchange lost at conversion end
`timescale 1ns/1ps
module adc_serial_ctrl
#(
   parameter int CHANNELS = 8
)
(
   input wire logic REF_CLK,
   input wire logic RST,
   input wire logic SERIAL_CLK,
   input wire logic CONV_CLK,
   input wire logic CHIP_SELECT_N,
   input wire logic OUTPUT_ENABLE_N,
   input wire logic SERIAL_IN,
   input wire logic [9:0] RESULT_IN,
   output logic SERIAL_OUT,
   output logic SERIAL_OUT_OE,
   output logic CONVERSION_ACTIVE,
   output logic SAMPLING,
   output logic [2:0] CHANNEL_SEL
);
   initial
   begin
      if (CHANNELS != adc_serial_pkg::VARIANT_ONE &&
          CHANNELS != adc_serial_pkg::VARIANT_FOUR &&
          CHANNELS != adc_serial_pkg::VARIANT_EIGHT)
         $error("CHANNELS must be 1, 4 or 8");
   end

   typedef enum logic [1:0] {IDLE, SAMPLE, CONVERT} phase_t;

   typedef struct packed {
      phase_t phase;
      logic [2:0] addr;
      logic justify;
      logic [2:0] bit_cnt;
      logic [3:0] half_cnt;
      logic [5:0] conv_cnt;
      logic [15:0] shift;
      logic [4:0] out_cnt;
      logic sout;
      logic busy;
   } state_t;

   state_t st_r;
   state_t st_nxt;
   logic sclk_rise;
   logic sclk_fall;
   logic conv_clk_rise;
   logic cs_lvl;
   logic cs_rise;
   logic oe_lvl;
   logic din_lvl;
   logic cs_n_eff;
   logic out_en;

   edge_sync u_sclk (.clk(REF_CLK), .rst(RST), .din(SERIAL_CLK),
      .level(), .rise(sclk_rise), .fall(sclk_fall));
   edge_sync u_conv_clk (.clk(REF_CLK), .rst(RST), .din(CONV_CLK),
      .level(), .rise(conv_clk_rise), .fall());
   // enables reset to deselected, so the pin is not driven during reset
   edge_sync #(.INIT(1'b1)) u_cs (.clk(REF_CLK), .rst(RST),
      .din(CHIP_SELECT_N),
      .level(cs_lvl), .rise(cs_rise), .fall());
   edge_sync #(.INIT(1'b1)) u_oe (.clk(REF_CLK), .rst(RST),
      .din(OUTPUT_ENABLE_N),
      .level(oe_lvl), .rise(), .fall());
   edge_sync u_din (.clk(REF_CLK), .rst(RST), .din(SERIAL_IN),
      .level(din_lvl), .rise(), .fall());

   // single-input variant has no output enable pin
   assign cs_n_eff = cs_lvl;
   assign out_en = (CHANNELS == adc_serial_pkg::VARIANT_ONE) ?
      ~cs_n_eff : (~cs_n_eff & ~oe_lvl);

   // build the 16-bit frame for a fresh result
   function automatic logic [15:0] frame(input logic [9:0] res,
                                         input logic right);
      if (right)
         frame = {6'h00, res};
      else
         frame = {res, 6'h00};
   endfunction : frame

   always_comb
   begin
      st_nxt = st_r;
      // address phase: no sampling until the header is complete
      if (st_r.phase == IDLE && !cs_n_eff && sclk_rise &&
          st_r.bit_cnt < 3'(adc_serial_pkg::HEADER_BITS))
      begin
         st_nxt.bit_cnt = st_r.bit_cnt + 3'h1;
         if (st_r.bit_cnt < 3'(adc_serial_pkg::ADDR_BITS))
            st_nxt.addr = {st_r.addr[1:0], din_lvl};
         else
         begin
            st_nxt.justify = (CHANNELS == adc_serial_pkg::VARIANT_ONE) ?
               1'b0 : din_lvl;
            st_nxt.phase = SAMPLE;
            st_nxt.half_cnt = 4'h0;
         end
      end
      if (cs_rise && st_r.phase == IDLE)
         st_nxt.bit_cnt = 3'h0;
      unique case (st_r.phase)
         IDLE:
         begin
         end
         SAMPLE:
         begin
            if (sclk_rise || sclk_fall)
               st_nxt.half_cnt = st_r.half_cnt + 4'h1;
            if (st_r.half_cnt == 4'(adc_serial_pkg::SAMPLE_HALVES))
            begin
               st_nxt.phase = CONVERT;
               st_nxt.busy = 1'b1;
               st_nxt.conv_cnt = 6'h0;
            end
         end
         CONVERT:
         begin
            if (conv_clk_rise)
               st_nxt.conv_cnt = st_r.conv_cnt + 6'h1;
            if (conv_clk_rise &&
                st_r.conv_cnt == 6'(adc_serial_pkg::CONV_CYCLES - 1))
            begin
               st_nxt.busy = 1'b0;
               st_nxt.phase = IDLE;
               st_nxt.bit_cnt = 3'h0;
               // an unread result is overwritten here
               st_nxt.shift = frame(RESULT_IN, st_r.justify);
               st_nxt.out_cnt = 5'h1;
               st_nxt.sout = RESULT_IN[9] & ~st_r.justify;
            end
         end
      endcase
      // output shifting, msb first, zeros once exhausted
      // the load wins over a shift falling in the same cycle
      if (out_en && sclk_fall &&
          !(st_r.phase == CONVERT && conv_clk_rise &&
            st_r.conv_cnt == 6'(adc_serial_pkg::CONV_CYCLES - 1)))
      begin
         st_nxt.shift = {st_r.shift[14:0], 1'b0};
         st_nxt.sout = st_r.shift[14];
         if (st_r.out_cnt < 5'(adc_serial_pkg::FRAME_BITS))
            st_nxt.out_cnt = st_r.out_cnt + 5'h1;
      end
   end

   always_ff @(posedge REF_CLK or posedge RST)
   begin
      if (RST)
      begin
         st_r.phase <= IDLE;
         st_r.addr <= adc_serial_pkg::ADDR_RESET;
         st_r.justify <= 1'b0;
         st_r.bit_cnt <= 3'h0;
         st_r.half_cnt <= 4'h0;
         st_r.conv_cnt <= 6'h0;
         st_r.shift <= adc_serial_pkg::SHIFT_RESET;
         st_r.out_cnt <= 5'h0;
         st_r.sout <= 1'b0;
         st_r.busy <= 1'b0;
      end
      else
         st_r <= st_nxt;
   end

   assign SERIAL_OUT = st_r.sout;
   assign SERIAL_OUT_OE = out_en;
   assign CONVERSION_ACTIVE = st_r.busy;
   assign SAMPLING = (st_r.phase == SAMPLE);
   // the mux address only moves in the idle phase, so sampling is stable
   assign CHANNEL_SEL = (CHANNELS == adc_serial_pkg::VARIANT_EIGHT) ?
      st_r.addr : (CHANNELS == adc_serial_pkg::VARIANT_FOUR) ?
      {1'b0, st_r.addr[1:0]} : 3'h0;

   sequence s_last_conv_clk;
      st_r.phase == CONVERT && conv_clk_rise &&
      st_r.conv_cnt == 6'(adc_serial_pkg::CONV_CYCLES - 1);
   endsequence

   a_busy_rise_sample: assert property (@(posedge REF_CLK) disable iff (RST)
      $rose(CONVERSION_ACTIVE) |-> $past(st_r.phase) == SAMPLE)
      else $error("busy rose outside sampling end");
   a_busy_len_count: assert property (@(posedge REF_CLK) disable iff (RST)
      s_last_conv_clk |=> $fell(CONVERSION_ACTIVE))
      else $error("busy did not fall after 41 clocks");
   a_busy_fall_count: assert property (@(posedge REF_CLK) disable iff (RST)
      $fell(CONVERSION_ACTIVE) |->
      $past(st_r.conv_cnt) == 6'(adc_serial_pkg::CONV_CYCLES - 1))
      else $error("busy fell early");
   a_load_on_end: assert property (@(posedge REF_CLK) disable iff (RST)
      s_last_conv_clk |=> st_r.out_cnt == 5'h1 && st_r.bit_cnt == 3'h0)
      else $error("result not loaded at conversion end");
   a_drive_gate: assert property (@(posedge REF_CLK) disable iff (RST)
      SERIAL_OUT_OE |-> !$past(CHIP_SELECT_N, 2) &&
      (CHANNELS == 1 || !$past(OUTPUT_ENABLE_N, 2)))
      else $error("output driven while disabled");
   a_sample_enter: assert property (@(posedge REF_CLK) disable iff (RST)
      st_r.phase == IDLE && !cs_n_eff && sclk_rise && st_r.bit_cnt == 3'h3
      |=> st_r.phase == SAMPLE)
      else $error("sampling not entered after fourth bit");
   a_sample_len: assert property (@(posedge REF_CLK) disable iff (RST)
      $rose(st_r.phase == CONVERT) |->
      $past(st_r.half_cnt) == 4'(adc_serial_pkg::SAMPLE_HALVES))
      else $error("sampling window not 4.5 cycles");
   a_addr_hold: assert property (@(posedge REF_CLK) disable iff (RST)
      st_r.phase != IDLE |=> $stable(st_r.addr))
      else $error("address changed after header");
   a_left_fmt: assert property (@(posedge REF_CLK) disable iff (RST)
      CHANNELS == 1 && st_r.phase == SAMPLE |-> !st_r.justify)
      else $error("single input not left justified");
   a_mux_four: assert property (@(posedge REF_CLK) disable iff (RST)
      CHANNELS == 4 |-> !CHANNEL_SEL[2])
      else $error("four input used address msb");
endmodule : adc_serial_ctrl

// >>> host_model.sv
/*
 host model: serial exchanges and a free running conversion clock.
 assumes the device samples both clocks with a much faster clock.
*/
`timescale 1ns/1ps
module host_model
(
   output logic sclk,
   output logic conv_clk,
   output logic cs_n,
   output logic oe_n,
   output logic sdi,
   input wire logic sdo
);
   initial
   begin
      sclk = 1'b0;
      conv_clk = 1'b0;
      cs_n = 1'b1;
      oe_n = 1'b1;
      sdi = 1'b0;
   end
   // never gated; 260 ns keeps it inside the allowed range
   always #130 conv_clk = ~conv_clk;
   // serial clock stands still outside frames
   task automatic xfer(input logic [3:0] hdr, input logic oe,
         output logic [15:0] rd);
      // step off the sampling clock edge before touching any pin
      #1;
      cs_n = 1'b0;
      oe_n = ~oe;
      sdi = hdr[3];
      #150;
      for (int i = 0; i < 16; i++)
      begin
         sclk = 1'b1;
         rd = {rd[14:0], sdo};
         #62.5;
         sclk = 1'b0;
         // trailing bits are garbage the device must not take
         sdi = (i < 3) ? hdr[2 - i] : ~sdi;
         #62.5;
      end
      #100;
      cs_n = 1'b1;
      oe_n = 1'b1;
      sdi = ~sdi;
   endtask : xfer
endmodule : host_model

// >>> adc_serial_ctrl_test.sv
/*
 testbench for the serial converter control block.
 assumes host_model drives the serial pins and the conversion clock.
*/
`timescale 1ns/1ps
module adc_serial_ctrl_test;
   logic REF_CLK, RST, SERIAL_CLK, CONV_CLK, SERIAL_IN;
   logic CHIP_SELECT_N, OUTPUT_ENABLE_N;
   logic [9:0] RESULT_IN;
   logic SERIAL_OUT, SERIAL_OUT_OE, CONVERSION_ACTIVE, SAMPLING;
   logic [2:0] CHANNEL_SEL;
   logic [2:0] sel4, sel1;
   logic sdo1, oe1, sdo_pin;
   logic [15:0] rd1;
   int n_samp = 0;
   // 4.5 periods of the 125 ns serial clock, in 10 ns cycles
   localparam int SAMP_LO = adc_serial_pkg::SAMPLE_HALVES * 125 / 20;
   logic [15:0] rd, exp_rd;
   logic [9:0] res, prev_res;
   logic prev_just, cur_oe;
   int n_mismatch = 0;
   int tests_run = 0;
   int n_conv = 0;
   int cyc = 0;

   adc_serial_ctrl #(.CHANNELS(8)) u_dut
   (
      .REF_CLK(REF_CLK),
      .RST(RST),
      .SERIAL_CLK(SERIAL_CLK),
      .CONV_CLK(CONV_CLK),
      .CHIP_SELECT_N(CHIP_SELECT_N),
      .OUTPUT_ENABLE_N(OUTPUT_ENABLE_N),
      .SERIAL_IN(SERIAL_IN),
      .RESULT_IN(RESULT_IN),
      .SERIAL_OUT(SERIAL_OUT),
      .SERIAL_OUT_OE(SERIAL_OUT_OE),
      .CONVERSION_ACTIVE(CONVERSION_ACTIVE),
      .SAMPLING(SAMPLING),
      .CHANNEL_SEL(CHANNEL_SEL)
   );

   adc_serial_ctrl #(.CHANNELS(4)) u_dut4
   (
      .REF_CLK(REF_CLK),
      .RST(RST),
      .SERIAL_CLK(SERIAL_CLK),
      .CONV_CLK(CONV_CLK),
      .CHIP_SELECT_N(CHIP_SELECT_N),
      .OUTPUT_ENABLE_N(OUTPUT_ENABLE_N),
      .SERIAL_IN(SERIAL_IN),
      .RESULT_IN(RESULT_IN),
      .SERIAL_OUT(),
      .SERIAL_OUT_OE(),
      .CONVERSION_ACTIVE(),
      .SAMPLING(),
      .CHANNEL_SEL(sel4)
   );

   adc_serial_ctrl #(.CHANNELS(1)) u_dut1
   (
      .REF_CLK(REF_CLK),
      .RST(RST),
      .SERIAL_CLK(SERIAL_CLK),
      .CONV_CLK(CONV_CLK),
      .CHIP_SELECT_N(CHIP_SELECT_N),
      .OUTPUT_ENABLE_N(OUTPUT_ENABLE_N),
      .SERIAL_IN(SERIAL_IN),
      .RESULT_IN(RESULT_IN),
      .SERIAL_OUT(sdo1),
      .SERIAL_OUT_OE(oe1),
      .CONVERSION_ACTIVE(),
      .SAMPLING(),
      .CHANNEL_SEL(sel1)
   );

   // a released pin shows the inverse, so a stale bit cannot pass
   assign sdo_pin = SERIAL_OUT_OE ? SERIAL_OUT : ~SERIAL_OUT;

   host_model u_host
   (
      .sclk(SERIAL_CLK),
      .conv_clk(CONV_CLK),
      .cs_n(CHIP_SELECT_N),
      .oe_n(OUTPUT_ENABLE_N),
      .sdi(SERIAL_IN),
      .sdo(sdo_pin)
   );

   task automatic chk(input string nm, input logic [15:0] exp,
         input logic [15:0] got);
      tests_run++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : tally_and_finish

   initial
   begin
      REF_CLK = 1'b0;
      forever #5 REF_CLK = ~REF_CLK;
   end

   // sampled after the rise, before the device can react to it
   always @(posedge CONV_CLK)
   begin
      #20;
      if (CONVERSION_ACTIVE === 1'b1)
         n_conv++;
   end

   always @(negedge SERIAL_CLK)
      if (!CHIP_SELECT_N)
      begin
         chk("output_enable", {15'h0000, cur_oe}, {15'h0000, SERIAL_OUT_OE});
         chk("output_enable_one", 16'h0001, {15'h0000, oe1});
      end

   // the single-input variant is read straight off its pin
   always @(posedge SERIAL_CLK)
      if (!CHIP_SELECT_N)
         rd1 = {rd1[14:0], sdo1};

   always @(posedge REF_CLK)
   begin
      cyc++;
      if (SAMPLING === 1'b1)
         n_samp++;
      if (cyc == 30000)
      begin
         n_mismatch++;
         tally_and_finish();
      end
   end

   initial
   begin
      RST = 1'b1;
      RESULT_IN = 10'h000;
      cur_oe = 1'b0;
      prev_res = 10'h000;
      prev_just = 1'b0;
      repeat (2) @(posedge REF_CLK);
      RST <= 1'b0;
      repeat (4) @(posedge REF_CLK);
      // every address, both formats, one frame with output disabled
      for (int k = 0; k < 9; k++)
      begin
         res = 10'(16'h00A5 * (k + 3));
         @(posedge REF_CLK);
         RESULT_IN <= res;
         cur_oe = (k != 5);
         n_conv = 0;
         n_samp = 0;
         exp_rd = prev_just ? {6'h00, prev_res} : {prev_res, 6'h00};
         u_host.xfer({k[2:0], k[1]}, cur_oe, rd);
         chk("channel", {13'h0000, k[2:0]}, {13'h0000, CHANNEL_SEL});
         if (k > 0 && cur_oe) // first readout after reset discarded
            chk("readout", exp_rd, rd);
         chk("channel_four", {13'h0000, 1'b0, k[1:0]}, {13'h0000, sel4});
         chk("channel_one", 16'h0000, {13'h0000, sel1});
         if (k > 0) // first readout after reset discarded
            chk("readout_one", {prev_res, 6'h00}, rd1);
         chk("sample_window", 16'h0001,
            {15'h0000, (n_samp >= SAMP_LO && n_samp <= SAMP_LO + 2)});
         for (int w = 0; w < 3000 && CONVERSION_ACTIVE !== 1'b0; w++)
            @(posedge REF_CLK);
         repeat (5) @(posedge REF_CLK);
         chk("conv_clocks", 16'(adc_serial_pkg::CONV_CYCLES), 16'(n_conv));
         chk("idle_enable", 16'h0000, {15'h0000, SERIAL_OUT_OE});
         chk("idle_enable_one", 16'h0000, {15'h0000, oe1});
         prev_res = res;
         prev_just = k[1];
         $display("test %0d done", k);
      end
      tally_and_finish();
   end
endmodule : adc_serial_ctrl_test
